// [design/ddcsm_consts.svh]
`ifndef DDCSM_CONSTS_SVH
`define DDCSM_CONSTS_SVH
// register indexes; the bus byte address is four times the index
`define DDCSM_IDX_SYNC      12'h300
`define DDCSM_IDX_CH0       12'h310
`define DDCSM_IDX_XFER      12'h00F
`define DDCSM_IDX_TUNE      12'h320
`define DDCSM_IDX_PHASE     12'h321
`define DDCSM_IDX_MODA      12'h322
`define DDCSM_IDX_MODB      12'h323
`define DDCSM_IDX_STAT      12'h324
`define DDCSM_ADDR_W        14
// sync control fields
`define DDCSM_B_UPD         7
`define DDCSM_B_NRST        4
`define DDCSM_B_ONESHOT     1
`define DDCSM_B_SYNCEN      0
`define DDCSM_SYNC_MASK     8'h93
// channel 0 fields
`define DDCSM_B_MIX         7
`define DDCSM_B_GAIN        6
`define DDCSM_B_IFHI        5
`define DDCSM_B_IFLO        4
`define DDCSM_B_C2R         3
`define DDCSM_CH0_MASK      8'hFF
`define DDCSM_B_XFER        0
`define DDCSM_RST8          8'h00
`define DDCSM_RST32         32'h00000000
`define DDCSM_IF_VAR        2'h0
`define DDCSM_IF_ZERO       2'h1
`define DDCSM_IF_FS         2'h2
`define DDCSM_IF_TEST       2'h3
`endif

// [design/ddcsm_pkg.sv]
package ddcsm_pkg;
  typedef enum logic [1:0] {DDCSM_IF_VARIABLE, DDCSM_IF_ZERO_HZ, DDCSM_IF_FS_HZ, DDCSM_IF_TEST_MODE} ddcsm_if_mode_t;
  typedef enum logic [1:0] {DDCSM_ST_IDLE, DDCSM_ST_ARMED, DDCSM_ST_CONT} ddcsm_sync_st_t;
endpackage

// [design/ddcsm_word_if.sv]
`timescale 1ns/1ns
// carries the oscillator word set between the bank and its holding stage
interface ddcsm_word_if #(parameter int W = 32);
  logic [W-1:0] tune;
  logic [W-1:0] phase;
  logic [W-1:0] moda;
  logic [W-1:0] modb;
  logic         load;
  modport src (output tune, output phase, output moda, output modb, output load);
  modport dst (input tune, input phase, input moda, input modb, input load);
endinterface

// [design/ddcsm_active_words.sv]
`timescale 1ns/1ns
`include "ddcsm_consts.svh"
// holds the word set that the oscillators really use; read data from registers
module ddcsm_active_words #(
  parameter int W = 32
) (
  input  wire logic     clk_sys,
  input  wire logic     rst_n,
  ddcsm_word_if.dst     wr,
  output logic [W-1:0]  tune_q,
  output logic [W-1:0]  phase_q,
  output logic [W-1:0]  moda_q,
  output logic [W-1:0]  modb_q
);
  // copy the whole set in one edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tune_q  <= W'(`DDCSM_RST32);
      phase_q <= W'(`DDCSM_RST32);
      moda_q  <= W'(`DDCSM_RST32);
      modb_q  <= W'(`DDCSM_RST32);
    end else if (wr.load) begin
      tune_q  <= wr.tune;
      phase_q <= wr.phase;
      moda_q  <= wr.moda;
      modb_q  <= wr.modb;
    end
  end
endmodule

// [design/ddcsm_bank.sv]
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "ddcsm_consts.svh"
// Notes on behaviour
// R1: update bit clear applies words on write
// R2: update bit set waits for transfer bit
// R3: soft reset bit holds oscillators reset
// R4: one-shot aligns once then clears enable
// R5: source keeps sysref integer multiple of oscillator
// R6: sync only with enable and sysref on
// R7: mixer bit selects real or complex
// R8: gain bit doubles filtered result
// R9: IF field decodes four IF modes
// R10: complex-to-real bit gives real output only
module ddcsm_bank #(
  parameter int W = 32
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [`DDCSM_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   sysref_pin,
  input  wire logic                   sysref_input_en,
  output logic                        nco_reset,
  output logic                        nco_align,
  output logic [W-1:0]                nco_tune,
  output logic [W-1:0]                nco_phase,
  output logic [W-1:0]                nco_moda,
  output logic [W-1:0]                nco_modb,
  output logic                        mix_complex,
  output logic                        gain_x2,
  output ddcsm_pkg::ddcsm_if_mode_t   if_mode,
  output logic                        real_out_only,
  output logic                        fs4_mix_en
);
  logic [7:0]   sync_r;
  logic [7:0]   ch0_r;
  logic [W-1:0] tune_r, phase_r, moda_r, modb_r;
  logic         pend_r;
  logic         rd_done_r;
  logic [31:0]  rdata_r;
  logic [2:0]   sref_r;
  ddcsm_pkg::ddcsm_sync_st_t st_r, st_nxt;
  ddcsm_word_if #(.W(W)) wif ();

  // byte index decode shared by read and write
  function automatic logic hit(input logic [`DDCSM_ADDR_W-1:0] a, input logic [11:0] idx);
    hit = (a[`DDCSM_ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  wire wr_go     = avs_write;
  wire wr_sync   = wr_go && hit(avs_address, `DDCSM_IDX_SYNC) && avs_byteenable[0];
  wire wr_ch0    = wr_go && hit(avs_address, `DDCSM_IDX_CH0) && avs_byteenable[0];
  wire wr_xfer   = wr_go && hit(avs_address, `DDCSM_IDX_XFER) && avs_byteenable[0]
                   && avs_writedata[`DDCSM_B_XFER];
  wire wr_tune   = wr_go && hit(avs_address, `DDCSM_IDX_TUNE);
  wire wr_phase  = wr_go && hit(avs_address, `DDCSM_IDX_PHASE);
  wire wr_moda   = wr_go && hit(avs_address, `DDCSM_IDX_MODA);
  wire wr_modb   = wr_go && hit(avs_address, `DDCSM_IDX_MODB);
  wire wr_word   = wr_tune | wr_phase | wr_moda | wr_modb;
  wire upd_sync  = sync_r[`DDCSM_B_UPD];
  wire sync_en   = sync_r[`DDCSM_B_SYNCEN];
  wire one_shot  = sync_r[`DDCSM_B_ONESHOT];

  // byte-enable merge for word registers
  function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = 32'(old);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) m[8*i +: 8] = d[8*i +: 8];
    end
    merge = W'(m);
  endfunction

  // immediate mode loads a cycle after the word write; held mode on transfer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= wr_word && !upd_sync; // R1
    end
  end
  assign wif.load  = pend_r | wr_xfer; // R1 R2
  assign wif.tune  = tune_r;
  assign wif.phase = phase_r;
  assign wif.moda  = moda_r;
  assign wif.modb  = modb_r;

  ddcsm_active_words #(.W(W)) u_act (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr      (wif),
    .tune_q  (nco_tune),
    .phase_q (nco_phase),
    .moda_q  (nco_moda),
    .modb_q  (nco_modb)
  );

  // staging word registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tune_r  <= W'(`DDCSM_RST32);
      phase_r <= W'(`DDCSM_RST32);
      moda_r  <= W'(`DDCSM_RST32);
      modb_r  <= W'(`DDCSM_RST32);
    end else begin
      if (wr_tune)  tune_r  <= merge(tune_r, avs_writedata, avs_byteenable);
      if (wr_phase) phase_r <= merge(phase_r, avs_writedata, avs_byteenable);
      if (wr_moda)  moda_r  <= merge(moda_r, avs_writedata, avs_byteenable);
      if (wr_modb)  modb_r  <= merge(modb_r, avs_writedata, avs_byteenable);
    end
  end

  // sysref synchroniser and rising edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) sref_r <= 3'h0;
    else        sref_r <= {sref_r[1:0], sysref_pin};
  end
  wire sref_edge = sref_r[1] & ~sref_r[2];
  wire sync_ok   = sync_en && sysref_input_en; // R6
  wire fire      = sync_ok && sref_edge && (st_r != ddcsm_pkg::DDCSM_ST_IDLE); // R6
  wire os_clear  = fire && (st_r == ddcsm_pkg::DDCSM_ST_ARMED); // R4

  // sync state: armed for one edge or continuous
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ddcsm_pkg::DDCSM_ST_IDLE:  if (sync_ok) st_nxt = one_shot ? ddcsm_pkg::DDCSM_ST_ARMED : ddcsm_pkg::DDCSM_ST_CONT;
      ddcsm_pkg::DDCSM_ST_ARMED: if (os_clear || !sync_ok) st_nxt = ddcsm_pkg::DDCSM_ST_IDLE; // R4
      ddcsm_pkg::DDCSM_ST_CONT:  if (!sync_ok || one_shot) st_nxt = ddcsm_pkg::DDCSM_ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) st_r <= ddcsm_pkg::DDCSM_ST_IDLE;
    else        st_r <= st_nxt;
  end

  // control registers; hardware clear of enable wins over a same-cycle write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= `DDCSM_RST8;
      ch0_r  <= `DDCSM_RST8;
    end else begin
      if (wr_sync) sync_r <= avs_writedata[7:0] & `DDCSM_SYNC_MASK;
      if (os_clear) sync_r[`DDCSM_B_SYNCEN] <= 1'b0; // R4
      if (wr_ch0)  ch0_r  <= avs_writedata[7:0] & `DDCSM_CH0_MASK;
    end
  end

  // outputs toward the oscillator and datapath
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nco_reset <= 1'b0;
      nco_align <= 1'b0;
    end else begin
      nco_reset <= sync_r[`DDCSM_B_NRST]; // R3
      nco_align <= fire; // R4 R6
    end
  end
  assign mix_complex   = ch0_r[`DDCSM_B_MIX];  // R7
  assign gain_x2       = ch0_r[`DDCSM_B_GAIN]; // R8
  assign if_mode       = ddcsm_pkg::ddcsm_if_mode_t'(ch0_r[`DDCSM_B_IFHI:`DDCSM_B_IFLO]); // R9
  assign real_out_only = ch0_r[`DDCSM_B_C2R];  // R10
  assign fs4_mix_en    = ch0_r[`DDCSM_B_C2R];  // R10

  // read mux; unmapped reads zero, reads take one wait cycle
  wire [31:0] rd_mux =
    hit(avs_address, `DDCSM_IDX_SYNC)  ? {24'h000000, sync_r} :
    hit(avs_address, `DDCSM_IDX_CH0)   ? {24'h000000, ch0_r} :
    hit(avs_address, `DDCSM_IDX_TUNE)  ? 32'(tune_r) :
    hit(avs_address, `DDCSM_IDX_PHASE) ? 32'(phase_r) :
    hit(avs_address, `DDCSM_IDX_MODA)  ? 32'(moda_r) :
    hit(avs_address, `DDCSM_IDX_MODB)  ? 32'(modb_r) :
    hit(avs_address, `DDCSM_IDX_STAT)  ? {29'h00000000, nco_reset, st_r} : 32'h00000000;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_done_r <= 1'b0;
      rdata_r   <= 32'h00000000;
    end else begin
      rd_done_r <= avs_read && !rd_done_r;
      if (avs_read && !rd_done_r) rdata_r <= rd_mux;
    end
  end
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = avs_read && !rd_done_r;

  // checks
  sequence s_edge_ok; sync_ok && sref_edge && st_r != ddcsm_pkg::DDCSM_ST_IDLE; endsequence
  property p_align;
    @(posedge clk_sys) disable iff (!rst_n) s_edge_ok |=> nco_align;
  endproperty
  a_align: assert property (p_align) else $error("align pulse missing"); // R6
  property p_noalign;
    @(posedge clk_sys) disable iff (!rst_n) !$past(sync_ok) |-> !nco_align;
  endproperty
  a_noalign: assert property (p_noalign) else $error("align without enable"); // R6
  property p_oneshot_clr;
    @(posedge clk_sys) disable iff (!rst_n) os_clear |=> !sync_r[`DDCSM_B_SYNCEN];
  endproperty
  a_oneshot_clr: assert property (p_oneshot_clr) else $error("one-shot enable not cleared"); // R4
  property p_immediate;
    @(posedge clk_sys) disable iff (!rst_n) (wr_tune && !upd_sync) |-> ##2 (nco_tune == $past(tune_r, 1));
  endproperty
  a_immediate: assert property (p_immediate) else $error("tuning word not applied"); // R1
  property p_held;
    @(posedge clk_sys) disable iff (!rst_n) (upd_sync && !pend_r && !wr_xfer) |=> $stable(nco_tune);
  endproperty
  a_held: assert property (p_held) else $error("held word changed"); // R2
  property p_xfer;
    @(posedge clk_sys) disable iff (!rst_n) wr_xfer |=> (nco_phase == $past(phase_r));
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer did not apply"); // R2
  property p_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_sync |-> ##2 (nco_reset == $past(avs_writedata[`DDCSM_B_NRST], 2));
  endproperty
  a_reset: assert property (p_reset) else $error("oscillator reset wrong"); // R3
  property p_c2r;
    @(posedge clk_sys) disable iff (!rst_n) wr_ch0 |=> (real_out_only == $past(avs_writedata[`DDCSM_B_C2R]))
      && (gain_x2 == $past(avs_writedata[`DDCSM_B_GAIN])) && (mix_complex == $past(avs_writedata[`DDCSM_B_MIX]));
  endproperty
  a_c2r: assert property (p_c2r) else $error("channel control mismatch"); // R7 R8 R10
  property p_ifm;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_ch0 |=> (if_mode == ddcsm_pkg::ddcsm_if_mode_t'($past(avs_writedata[`DDCSM_B_IFHI:`DDCSM_B_IFLO])));
  endproperty
  a_ifm: assert property (p_ifm) else $error("IF mode decode wrong"); // R9
endmodule

// [bench/ddcsm_sysref_src.sv]
`timescale 1ns/1ns
// external timing source: a square sysref that is low whenever it is not asked to run
module ddcsm_sysref_src #(
  parameter int HALF = 4
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output logic      sysref_pin
);
  int cnt;
  // period is 2*HALF sample cycles, an integer multiple of the oscillator rate used here
  always @(posedge clk_sys) begin
    if (!run) begin
      cnt <= 0;
      sysref_pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      sysref_pin <= ~sysref_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [bench/tb_ddc_sync_and_mixer_control.sv]
`timescale 1ns/1ns
`include "ddcsm_consts.svh"
// self-checking bench for the downconverter sync and mixer control bank
module tb_ddc_sync_and_mixer_control;
  logic                          clk_sys;
  logic                          rst_n;
  logic [13:0]                   avs_address;
  logic                          avs_read;
  logic                          avs_write;
  logic [31:0]                   avs_writedata;
  logic [31:0]                   avs_readdata;
  logic                          avs_waitrequest;
  logic                          sysref_pin;
  logic                          sysref_input_en;
  logic                          src_run;
  logic                          nco_reset;
  logic                          nco_align;
  logic [31:0]                   nco_tune;
  logic [31:0]                   nco_phase;
  logic [31:0]                   nco_moda;
  logic [31:0]                   nco_modb;
  logic                          mix_complex;
  logic                          gain_x2;
  ddcsm_pkg::ddcsm_if_mode_t     if_mode;
  logic                          real_out_only;
  logic                          fs4_mix_en;
  int                            errors;
  int                            cmp_count;
  int                            pulses;
  integer                        seed;
  logic [31:0]                   q;
  logic [31:0]                   w [4];
  logic [7:0]                    d;
  logic [31:0]                   nco_v [4];

  // active oscillator words in register order, for indexed checks
  always_comb begin
    nco_v[0] = nco_tune;
    nco_v[1] = nco_phase;
    nco_v[2] = nco_moda;
    nco_v[3] = nco_modb;
  end

  ddcsm_bank dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sysref_pin(sysref_pin), .sysref_input_en(sysref_input_en),
    .nco_reset(nco_reset), .nco_align(nco_align), .nco_tune(nco_tune), .nco_phase(nco_phase),
    .nco_moda(nco_moda), .nco_modb(nco_modb), .mix_complex(mix_complex), .gain_x2(gain_x2),
    .if_mode(if_mode), .real_out_only(real_out_only), .fs4_mix_en(fs4_mix_en));
  ddcsm_sysref_src src_u (.clk_sys(clk_sys), .run(src_run), .sysref_pin(sysref_pin));

  // byte address from register index
  function automatic logic [13:0] ra(input logic [11:0] i);
    ra = {i, 2'b00};
  endfunction
  // expected read-back of sync control: reserved bits read zero
  function automatic logic [31:0] sync_rd(input logic [7:0] v);
    sync_rd = {24'h000000, v & `DDCSM_SYNC_MASK};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one bus transfer: held until waitrequest is sampled low at a rising edge, released at that edge
  task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] v, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
      n++;
    end
    check(n, wr ? 0 : 1);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // counts alignment pulses over a window while the source runs
  task automatic sync_window(input logic en, output int cnt);
    int p0;
    p0 = pulses;
    src_run <= en;
    repeat (70) @(posedge clk_sys);
    src_run <= 1'b0;
    repeat (8) @(posedge clk_sys);
    cnt = pulses - p0;
  endtask

  always @(posedge clk_sys) begin
    if (nco_align === 1'b1) pulses <= pulses + 1;
  end

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    conclude();
  end

  initial begin
    int k;
    seed = 32'h19fd;
    errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    avs_address = 14'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    sysref_input_en = 1'b0;
    src_run = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values and reserved bits of sync control
    bus(1'b0, ra(`DDCSM_IDX_SYNC), 32'h0, q);
    check(q, 32'h00000000);
    check(nco_reset, 1'b0);
    check(nco_tune, 32'h00000000);
    d = 8'($random(seed));
    bus(1'b1, ra(`DDCSM_IDX_SYNC), {24'h0, d & 8'h6E}, q);
    bus(1'b0, ra(`DDCSM_IDX_SYNC), 32'h0, q);
    check(q, sync_rd(d & 8'h6E));
    bus(1'b1, ra(`DDCSM_IDX_SYNC), 32'h0, q);
    // immediate update of the four words
    for (k = 0; k < 4; k++) begin
      w[k] = $random(seed);
      bus(1'b1, ra(12'(`DDCSM_IDX_TUNE + k)), w[k], q);
    end
    repeat (3) @(posedge clk_sys);
    for (k = 0; k < 4; k++) check(nco_v[k], w[k]);
    // held update: nothing moves until the transfer bit
    bus(1'b1, ra(`DDCSM_IDX_SYNC), 32'h80, q);
    for (k = 0; k < 4; k++) bus(1'b1, ra(12'(`DDCSM_IDX_TUNE + k)), ~w[k], q);
    repeat (3) @(posedge clk_sys);
    for (k = 0; k < 4; k++) check(nco_v[k], w[k]);
    bus(1'b1, ra(`DDCSM_IDX_XFER), 32'h1, q);
    repeat (2) @(posedge clk_sys);
    for (k = 0; k < 4; k++) check(nco_v[k], ~w[k]);
    // soft reset of the oscillators
    bus(1'b1, ra(`DDCSM_IDX_SYNC), 32'h10, q);
    repeat (2) @(posedge clk_sys);
    check(nco_reset, 1'b1);
    bus(1'b0, ra(`DDCSM_IDX_STAT), 32'h0, q);
    check(q[2], 1'b1);
    bus(1'b1, ra(`DDCSM_IDX_SYNC), 32'h00, q);
    repeat (2) @(posedge clk_sys);
    check(nco_reset, 1'b0);
    // sync ignored without enable bit or without sysref input enabled
    sysref_input_en <= 1'b1;
    sync_window(1'b1, k);
    check(k, 0);
    sysref_input_en <= 1'b0;
    bus(1'b1, ra(`DDCSM_IDX_SYNC), 32'h01, q);
    sync_window(1'b1, k);
    check(k, 0);
    // one-shot: a single alignment, then the enable bit clears
    sysref_input_en <= 1'b1;
    bus(1'b1, ra(`DDCSM_IDX_SYNC), 32'h03, q);
    sync_window(1'b1, k);
    check(k, 1);
    bus(1'b0, ra(`DDCSM_IDX_SYNC), 32'h0, q);
    check(q, 32'h00000002);
    // continuous: rising sysref edges keep realigning, at least three pulses counted
    bus(1'b1, ra(`DDCSM_IDX_SYNC), 32'h01, q);
    sync_window(1'b1, k);
    check(k >= 3, 1'b1);
    bus(1'b1, ra(`DDCSM_IDX_SYNC), 32'h00, q);
    // channel 0 controls over every IF mode
    for (k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      d[5:4] = k[1:0];
      bus(1'b1, ra(`DDCSM_IDX_CH0), {24'h0, d}, q);
      repeat (2) @(posedge clk_sys);
      check({mix_complex, gain_x2}, d[7:6]);
      check(if_mode, d[5:4]);
      check({real_out_only, fs4_mix_en}, {d[3], d[3]});
      bus(1'b0, ra(`DDCSM_IDX_CH0), 32'h0, q);
      check(q, {24'h0, d});
    end
    // unmapped and misaligned addresses read zero
    bus(1'b1, 14'h3FFC, 32'hFFFFFFFF, q);
    bus(1'b0, 14'h3FFC, 32'h0, q);
    check(q, 32'h00000000);
    bus(1'b0, ra(`DDCSM_IDX_CH0) + 14'h0001, 32'h0, q);
    check(q, 32'h00000000);
    conclude();
  end
endmodule
